// ### core/mwm_monitor.sv
`timescale 1ns/10ps
`include "mwm_map.svh"
module mwm_motion_window_monitor
  import mwm_pkg::*;
#(
  parameter int TICK_CYCLES = `MWM_MS_CYCLES
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Object dictionary access.
  input  wire logic       i_od_req,
  input  wire logic       i_od_write,
  input  wire mwm_index_t i_od_index,
  input  wire logic [31:0] i_od_wdata,
  output logic            o_od_ack,
  output logic            o_od_err,
  output logic [31:0]     o_od_rdata,
  // Motion inputs from encoder, speed measurement and ramp generator.
  input  wire mwm_mode_t  i_mode,
  input  wire mwm_word_t  i_pos_demand,
  input  wire mwm_word_t  i_pos_actual,
  input  wire mwm_word_t  i_pos_target,
  input  wire mwm_word_t  i_vel_demand,
  input  wire mwm_word_t  i_vel_actual,
  input  wire logic [31:0] i_fe_window,
  input  wire logic       i_fe_reaction,
  input  wire logic signed [15:0] i_target_torque,
  // Status and values.
  output logic [15:0]     o_status_bits,
  output logic            o_err_entry,
  output mwm_word_t       o_vel_demand,
  output mwm_word_t       o_vel_actual,
  output logic            o_torque_over_rated
);

  logic [15:0] fe_timeout_reg;
  logic [31:0] pos_win_reg;
  logic [15:0] pos_win_time_reg;
  logic [15:0] vel_win_reg;
  logic [15:0] vel_win_time_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic        fe_flag_reg;
  logic        tr_flag_reg;
  logic        err_reg;
  logic        ack_reg;
  logic        err_resp_reg;
  logic [31:0] rdata_reg;
  mwm_word_t   vel_dem_reg;
  mwm_word_t   vel_act_reg;
  logic        torque_reg;
  logic        fe_over;
  logic        pos_in;
  logic        vel_in;
  logic        fe_met;
  logic        pos_met;
  logic        vel_met;
  logic        pos_mode;
  logic        vel_mode;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  function automatic logic [32:0] absdiff(input mwm_word_t a,
                                          input mwm_word_t b);
    logic signed [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  function automatic logic writable(input mwm_index_t idx);
    return idx == `MWM_IDX_FE_TIMEOUT || idx == `MWM_IDX_POS_WIN ||
           idx == `MWM_IDX_POS_WIN_TIME || idx == `MWM_IDX_VEL_WIN ||
           idx == `MWM_IDX_VEL_WIN_TIME;
  endfunction

  function automatic logic readable(input mwm_index_t idx);
    return writable(idx) || idx == `MWM_IDX_VEL_DEMAND ||
           idx == `MWM_IDX_VEL_ACTUAL;
  endfunction

  // Millisecond time base.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    tick_reg <= i_reset_n && tick_cnt_reg == 32'(TICK_CYCLES - 1);
  end

  // Host writable parameters.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fe_timeout_reg   <= `MWM_FE_TIMEOUT_RST;
      pos_win_reg      <= `MWM_POS_WIN_RST;
      pos_win_time_reg <= `MWM_POS_WIN_TIME_RST;
      vel_win_reg      <= `MWM_VEL_WIN_RST;
      vel_win_time_reg <= `MWM_VEL_WIN_TIME_RST;
    end else if (i_od_req && i_od_write) begin
      unique case (i_od_index)
        `MWM_IDX_FE_TIMEOUT:   fe_timeout_reg   <= i_od_wdata[15:0];
        `MWM_IDX_POS_WIN:      pos_win_reg      <= i_od_wdata;
        `MWM_IDX_POS_WIN_TIME: pos_win_time_reg <= i_od_wdata[15:0];
        `MWM_IDX_VEL_WIN:      vel_win_reg      <= i_od_wdata[15:0];
        `MWM_IDX_VEL_WIN_TIME: vel_win_time_reg <= i_od_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Answer one cycle after the request; writes to read-only or unknown
  // indexes are refused with the error flag.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ack_reg      <= 1'b0;
      err_resp_reg <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      ack_reg      <= i_od_req;
      err_resp_reg <= i_od_req && (i_od_write ? !writable(i_od_index)
                                              : !readable(i_od_index));
      if (i_od_req && !i_od_write) begin
        unique case (i_od_index)
          `MWM_IDX_FE_TIMEOUT:   rdata_reg <= {16'h0000, fe_timeout_reg};
          `MWM_IDX_POS_WIN:      rdata_reg <= pos_win_reg;
          `MWM_IDX_POS_WIN_TIME: rdata_reg <= {16'h0000, pos_win_time_reg};
          `MWM_IDX_VEL_DEMAND:   rdata_reg <= vel_dem_reg;
          `MWM_IDX_VEL_ACTUAL:   rdata_reg <= vel_act_reg;
          `MWM_IDX_VEL_WIN:      rdata_reg <= {16'h0000, vel_win_reg};
          `MWM_IDX_VEL_WIN_TIME: rdata_reg <= {16'h0000, vel_win_time_reg};
          default:               rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sampled values; the demand value also serves as the speed setpoint.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vel_dem_reg <= 32'sh0000_0000;
      vel_act_reg <= 32'sh0000_0000;
    end else begin
      vel_dem_reg <= i_vel_demand;
      vel_act_reg <= i_vel_actual;
    end
  end

  assign pos_mode = i_mode == `MWM_MODE_PP || i_mode == `MWM_MODE_IP;
  assign vel_mode = i_mode == `MWM_MODE_PV;
  // The window is symmetric, so the magnitude of the gap is compared.
  assign fe_over = i_fe_window != `MWM_WIN_OFF &&
                   absdiff(i_pos_actual, i_pos_demand) >
                   {1'b0, i_fe_window};
  assign pos_in  = pos_mode && pos_win_reg != `MWM_WIN_OFF &&
                   absdiff(i_pos_actual, i_pos_target) <
                   {1'b0, pos_win_reg};
  assign vel_in  = vel_mode &&
                   absdiff(i_vel_actual, i_vel_demand) <
                   {17'h0_0000, vel_win_reg};

  mwm_persist u_fe_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_tick    (tick_reg),
    .i_cond    (fe_over),
    .i_limit   (fe_timeout_reg),
    .o_met     (fe_met)
  );

  // The position window time qualifies position targets.
  mwm_persist u_pos_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_tick    (tick_reg),
    .i_cond    (pos_in),
    .i_limit   (pos_win_time_reg),
    .o_met     (pos_met)
  );

  mwm_persist u_vel_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_tick    (tick_reg),
    .i_cond    (vel_in),
    .i_limit   (vel_win_time_reg),
    .o_met     (vel_met)
  );

  // Status flags follow the timers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fe_flag_reg <= 1'b0;
      tr_flag_reg <= 1'b0;
      err_reg     <= 1'b0;
    end else begin
      fe_flag_reg <= fe_met;
      tr_flag_reg <= pos_met || vel_met;
      err_reg     <= fe_met && !fe_flag_reg && i_fe_reaction;
    end
  end

  // Torque modes: flag a target beyond rated torque in either direction, 1000 tenths.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      torque_reg <= 1'b0;
    end else begin
      torque_reg <= (i_mode == `MWM_MODE_PT || i_mode == `MWM_MODE_CST) &&
                    (i_target_torque > $signed(`MWM_TORQUE_RATED) ||
                     i_target_torque < -$signed(`MWM_TORQUE_RATED));
    end
  end

  always_comb begin
    o_status_bits = 16'h0000;
    o_status_bits[`MWM_SW_FOLLOW_BIT] = fe_flag_reg;
    o_status_bits[`MWM_SW_TARGET_BIT] = tr_flag_reg;
  end

  assign o_od_ack            = ack_reg;
  assign o_od_err            = err_resp_reg;
  assign o_od_rdata          = rdata_reg;
  assign o_err_entry         = err_reg;
  assign o_vel_demand        = vel_dem_reg;
  assign o_vel_actual        = vel_act_reg;
  assign o_torque_over_rated = torque_reg;

  follow_flag_a: assert property (fe_flag_reg |-> $past(fe_over))
    else $error("Following error flag without deviation.");
  fe_reset_a: assert property ($rose(i_reset_n)
    |-> fe_timeout_reg == `MWM_FE_TIMEOUT_RST)
    else $error("Following error timeout reset value wrong.");
  err_entry_a: assert property (o_err_entry
    |-> $past(i_fe_reaction) && fe_flag_reg && !$past(fe_flag_reg))
    else $error("Error entry without configured reaction.");
  pos_reach_a: assert property ((tr_flag_reg && $past(pos_mode))
    |-> $past(pos_in) && $past(pos_met))
    else $error("Position target flag without window hold.");
  pos_off_a: assert property ((pos_win_reg == `MWM_WIN_OFF)
    |=> !tr_flag_reg || $past(vel_met))
    else $error("Position monitoring active while disabled.");
  vel_reach_a: assert property ((tr_flag_reg && $past(vel_mode))
    |-> $past(vel_in))
    else $error("Velocity target flag outside window.");
  vel_value_a: assert property (i_reset_n
    |=> o_vel_actual == $past(i_vel_actual)
        && o_vel_demand == $past(i_vel_demand))
    else $error("Velocity values not tracked.");
  fe_off_a: assert property ((i_fe_window == `MWM_WIN_OFF)[*2]
    |=> !fe_flag_reg)
    else $error("Following monitoring active while disabled.");
  vel_time_a: assert property ($rose(i_reset_n)
    |-> vel_win_time_reg == `MWM_VEL_WIN_TIME_RST
        && vel_win_reg == `MWM_VEL_WIN_RST)
    else $error("Velocity window reset values wrong.");

  fe_seen_c: cover property ($rose(fe_flag_reg));
  tr_seen_c: cover property ($rose(tr_flag_reg));
  err_seen_c: cover property (o_err_entry);
  od_write_c: cover property (i_od_req && i_od_write ##1 o_od_ack);

endmodule // mwm_motion_window_monitor

// ### core/mwm_map.svh
`ifndef MWM_MAP_SVH
`define MWM_MAP_SVH

// Object dictionary indexes.
`define MWM_IDX_FE_TIMEOUT   16'h6066
`define MWM_IDX_POS_WIN      16'h6067
`define MWM_IDX_POS_WIN_TIME 16'h6068
`define MWM_IDX_VEL_DEMAND   16'h606B
`define MWM_IDX_VEL_ACTUAL   16'h606C
`define MWM_IDX_VEL_WIN      16'h606D
`define MWM_IDX_VEL_WIN_TIME 16'h606E

// Reset values.
`define MWM_FE_TIMEOUT_RST   16'h0064
`define MWM_POS_WIN_RST      32'h0000_000A
`define MWM_POS_WIN_TIME_RST 16'h0064
`define MWM_VEL_WIN_RST      16'h001E
`define MWM_VEL_WIN_TIME_RST 16'h0000
`define MWM_FE_WIN_RST       32'h0000_0100
`define MWM_WIN_OFF          32'hFFFF_FFFF

// Statusword bit positions.
`define MWM_SW_TARGET_BIT    10
`define MWM_SW_FOLLOW_BIT    13

// Operating mode codes.
`define MWM_MODE_PP          8'h01
`define MWM_MODE_PV          8'h03
`define MWM_MODE_PT          8'h04
`define MWM_MODE_IP          8'h07
`define MWM_MODE_CST         8'h0A

// Torque scale: rated torque in tenths of a percent.
`define MWM_TORQUE_RATED     16'h03E8

// Time base.
`define MWM_MS_NS            1000000
`define MWM_CLK_NS           8
`define MWM_MS_CYCLES        (`MWM_MS_NS / `MWM_CLK_NS)

`endif

// ### core/mwm_pkg.sv
package mwm_pkg;
  typedef logic [15:0] mwm_index_t;
  typedef logic [7:0]  mwm_mode_t;
  typedef logic [15:0] mwm_ms_t;
  typedef logic signed [31:0] mwm_word_t;
endpackage

// ### core/mwm_persist.sv
`timescale 1ns/10ps
`include "mwm_map.svh"
module mwm_persist
  import mwm_pkg::*;
(
  // Clock and reset.
  input  wire logic    i_clk,
  input  wire logic    i_reset_n,
  // Time base and condition.
  input  wire logic    i_tick,
  input  wire logic    i_cond,
  input  wire mwm_ms_t i_limit,
  // Result.
  output logic         o_met
);

  logic [16:0] count_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Saturation keeps a long hold from wrapping back inside the limit.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_cond) begin
      count_reg <= 17'h0_0000;
    end else if (i_tick && count_reg != 17'h1_FFFF) begin
      count_reg <= count_reg + 17'h0_0001;
    end
  end

  assign o_met = i_cond && (count_reg > {1'b0, i_limit});

  timer_restart_a: assert property (
    !$past(i_cond) |-> count_reg == 17'h0_0000)
    else $error("Timer did not restart after condition lapsed.");
  met_limit_a: assert property (
    o_met |-> $past(i_cond) && count_reg != 17'h0_0000)
    else $error("Met raised without a held condition.");
  tick_only_a: assert property (
    (count_reg != $past(count_reg) && i_cond && $past(i_cond))
      |-> $past(i_tick))
    else $error("Timer advanced without a millisecond tick.");

endmodule // mwm_persist

// ### bench/mwm_motion_model.sv
`timescale 1ns/10ps
module mwm_motion_model
  import mwm_pkg::*;
(
  // Clock.
  input  wire logic      i_clk,
  // Commanded motion.
  input  wire mwm_word_t i_base,
  input  wire mwm_word_t i_pos_off,
  input  wire mwm_word_t i_vel_set,
  input  wire mwm_word_t i_vel_off,
  // Encoder and ramp generator outputs.
  output mwm_word_t      o_pos_demand,
  output mwm_word_t      o_pos_actual,
  output mwm_word_t      o_vel_demand,
  output mwm_word_t      o_vel_actual
);
  // The encoder and ramp are sampled, so every value lags by one cycle.
  always_ff @(posedge i_clk) begin
    o_pos_demand <= i_base;
    o_pos_actual <= i_base + i_pos_off;
    o_vel_demand <= i_vel_set;
    o_vel_actual <= i_vel_set + i_vel_off;
  end
endmodule // mwm_motion_model

// ### bench/mwm_motion_window_monitor_bench.sv
`timescale 1ns/10ps
`include "mwm_map.svh"
module mwm_motion_window_monitor_bench
  import mwm_pkg::*;
;
  // A short millisecond keeps every timer scenario within a few cycles.
  localparam int T = 4;
  localparam logic [31:0] RST [9] = '{32'h0000_0064, 32'h0000_000A,
    32'h0000_0064, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_001E, 32'h0};
  localparam mwm_mode_t MODES [6] = '{8'h04, 8'h04, 8'h0A, 8'h0A, 8'h03,
    8'h04};
  localparam int TQ [6] = '{1001, 1000, -1001, -1000, 1001, -1001};
  logic               clk = 0;
  logic               reset_n = 0;
  logic               od_req = 0;
  logic               od_write = 0;
  mwm_index_t         od_index = '0;
  logic [31:0]        od_wdata = '0;
  mwm_mode_t          mode = '0;
  mwm_word_t          base = '0;
  mwm_word_t          poff = '0;
  mwm_word_t          vset = '0;
  mwm_word_t          voff = '0;
  mwm_word_t          target = '0;
  logic [31:0]        fe_win = `MWM_FE_WIN_RST;
  logic               fe_react = 0;
  logic signed [15:0] torque = '0;
  logic               ack, err, over, entry;
  logic [31:0]        rdata;
  logic [15:0]        status;
  mwm_word_t          pd, pa, vd, va, vd_o, va_o;
  int                 num_errors = 0;
  int                 compares = 0;
  int                 entries = 0;

  mwm_motion_model i_model (.i_clk(clk), .i_base(base), .i_pos_off(poff),
    .i_vel_set(vset), .i_vel_off(voff), .o_pos_demand(pd),
    .o_pos_actual(pa), .o_vel_demand(vd), .o_vel_actual(va));
  mwm_motion_window_monitor #(.TICK_CYCLES(T)) i_dut (.i_clk(clk),
    .i_reset_n(reset_n), .i_od_req(od_req), .i_od_write(od_write),
    .i_od_index(od_index), .i_od_wdata(od_wdata), .o_od_ack(ack),
    .o_od_err(err), .o_od_rdata(rdata), .i_mode(mode),
    .i_pos_demand(pd), .i_pos_actual(pa), .i_pos_target(target),
    .i_vel_demand(vd), .i_vel_actual(va), .i_fe_window(fe_win),
    .i_fe_reaction(fe_react), .i_target_torque(torque),
    .o_status_bits(status), .o_err_entry(entry), .o_vel_demand(vd_o),
    .o_vel_actual(va_o), .o_torque_over_rated(over));

  always #4 clk = ~clk;

  // Counted on the falling edge so the pulse is never raced at its edge.
  always @(negedge clk) begin
    if (entry === 1'b1)
      entries++;
  end

  function automatic logic over_exp(input mwm_mode_t m, input int t);
    return (m == `MWM_MODE_PT || m == `MWM_MODE_CST) &&
      (t > 1000 || t < -1000);
  endfunction

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic od(input logic w, input mwm_index_t ix,
                    input logic [31:0] wd, input logic e,
                    input logic [31:0] rd);
    @(posedge clk);
    od_req <= 1'b1;
    od_write <= w;
    od_index <= ix;
    od_wdata <= wd;
    @(posedge clk);
    od_req <= 1'b0;
    #1;
    chk("od ack", 1, 32'(ack));
    chk("od err", 32'(e), 32'(err));
    if (!w)
      chk("od rdata", rd, rdata);
    @(posedge clk);
    #1;
    chk("od ack drop", 0, 32'(ack));
  endtask

  task automatic timed(input int b, input int lim);
    int n;
    n = 0;
    #1;
    while (status[b] !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > (lim + 2) * T + 4) begin
        num_errors++;
        $display("MISMATCH status bit %0d expected 1 seen 0", b);
        end_sim();
      end
    end
    chk("hold time", 1, 32'(n > lim * T));
  endtask

  task automatic stays_off(input int b, input int cyc);
    repeat (3) @(posedge clk);
    repeat (cyc) begin
      @(posedge clk);
      #1;
      chk("bit held off", 0, 32'(status[b]));
      chk("status spare", 0, 32'(status & 16'hDBFF));
    end
  endtask

  initial begin
    void'($urandom(32'he4d8));
    repeat (19) @(posedge clk);
    #1;
    chk("vel out in reset", 0, 32'(va_o | vd_o));
    @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      od(0, 16'h6066 + 16'(k), '0, k == 3 || k == 4, RST[k]);
    end
    od(1, 16'h6066, 32'hABCD_0002, 0, '0);
    od(0, 16'h6066, '0, 0, 32'h0000_0002);
    od(1, 16'h606B, 32'h1234_5678, 1, '0);
    od(1, 16'h606C, 32'h1234_5678, 1, '0);
    repeat (4) begin
      @(posedge clk);
      vset <= $urandom & 32'h0FFF_FFFF;
      voff <= $urandom & 32'h00FF_FFFF;
      repeat (3) @(posedge clk);
      #1;
      chk("vel demand", vset, vd_o);
      chk("vel actual", vset + voff, va_o);
      od(0, 16'h606B, '0, 0, vset);
      od(0, 16'h606C, '0, 0, vset + voff);
    end
    @(posedge clk);
    mode <= `MWM_MODE_PP;
    base <= $urandom & 32'h0FFF_FFFF;
    target <= 32'h7000_0000;
    fe_react <= 1'b1;
    poff <= 32'h0000_0100;
    stays_off(13, 6 * T);
    @(posedge clk);
    poff <= 32'h0000_0101;
    timed(13, 2);
    @(posedge clk);
    poff <= '0;
    fe_react <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("follow lapse", 0, 32'(status[13]));
    chk("error entry", 1, entries);
    @(posedge clk);
    poff <= -32'sd257;
    timed(13, 2);
    @(posedge clk);
    fe_win <= `MWM_WIN_OFF;
    stays_off(13, 4 * T);
    chk("error entry", 1, entries);
    od(1, 16'h6068, 32'h0000_0001, 0, '0);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      mode <= m ? `MWM_MODE_IP : `MWM_MODE_PP;
      target <= base + poff + 32'($urandom_range(18)) - 32'sd9;
      timed(10, 1);
      @(posedge clk);
      target <= base + poff + 32'sd10;
      stays_off(10, 4 * T);
    end
    @(posedge clk);
    target <= base + poff;
    mode <= `MWM_MODE_PT;
    stays_off(10, 4 * T);
    od(1, 16'h6067, `MWM_WIN_OFF, 0, '0);
    @(posedge clk);
    mode <= `MWM_MODE_PP;
    stays_off(10, 4 * T);
    @(posedge clk);
    mode <= `MWM_MODE_PV;
    voff <= 32'($urandom_range(58)) - 32'sd29;
    timed(10, 0);
    @(posedge clk);
    voff <= -32'sd30;
    stays_off(10, 4 * T);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      mode <= MODES[k];
      torque <= 16'(TQ[k]);
      repeat (3) @(posedge clk);
      #1;
      chk("torque over", 32'(over_exp(MODES[k], TQ[k])), 32'(over));
    end
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    od(0, `MWM_IDX_FE_TIMEOUT, '0, 0, RST[0]);
    od(0, `MWM_IDX_POS_WIN, '0, 0, RST[1]);
    chk("status after reset", 0, 32'(status));
    end_sim();
  end
endmodule // mwm_motion_window_monitor_bench
